/* File: src/sdamfc_top.sv */
// converter power mode, filter configuration, comparator, counter and accumulator
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module sdamfc_top (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   input wire logic i_hf_mod_clk,
   input wire logic i_lp_osc,
   input wire logic i_cur_bit,
   input wire logic i_vt_bit,
   output logic o_cur_en,
   output logic o_vt_en,
   output logic o_lp_clk_sel,
   output logic o_lp_ref_sel,
   output logic [3:0] o_gain_log2,
   output logic o_cur_chop,
   output logic o_vt_chop,
   output logic o_cur_valid,
   output logic o_cmp_irq,
   output logic o_cnt_irq
);
   // ****************************************************************
   // registers
   // ****************************************************************
   logic [7:0] converter_mode_register;
   sdamfc_pkg::sdamfc_flt_s decimation_filter_config;
   logic [15:0] converter_config_register;
   logic [15:0] current_threshold_level;
   logic [7:0] threshold_event_counter;
   logic [7:0] threshold_count_limit;
   logic signed [31:0] current_result_accumulator;
   logic signed [15:0] cur_data, vt_data;
   logic cur_ready, vt_ready;
   sdamfc_pkg::sdamfc_state_e st;
   sdamfc_pkg::sdamfc_flt_s flt_eff;
   logic [3:0] sync1, sync2;
   logic [1:0] clk_prev;
   logic tick, run, restart;
   logic cur_v, vt_v;
   logic signed [15:0] cur_res, vt_res;
   logic [1:0] pwr, cmp_mode, acc_mode;
   logic lp, wr_mode, wr_flt, wr_cfg;
   logic [15:0] mag;
   logic [7:0] next_count;

   function automatic logic [15:0] magnitude(input logic signed [15:0] v);
      magnitude = v[15] ? 16'(-v) : v;
   endfunction

   // keeps the total decimation within what the datapath can hold
   function automatic logic [5:0] clamp_avg(input logic [6:0] dec, input logic [5:0] avg,
                                            input logic [12:0] lim);
      logic [12:0] room;
      room = 13'(lim / (13'(dec) + 13'h0001));
      clamp_avg = (13'(avg) + 13'h0001 > room) ? 6'(room - 13'h0001) : avg;
   endfunction

   assign pwr = converter_mode_register[sdamfc_pkg::MODE_PWR_LSB +: 2];
   assign lp = (pwr == sdamfc_pkg::PWR_LP) || (pwr == sdamfc_pkg::PWR_LPP);
   assign cmp_mode = converter_config_register[sdamfc_pkg::CFG_CMP_LSB +: 2];
   assign acc_mode = converter_config_register[sdamfc_pkg::CFG_ACC_LSB +: 2];
   assign wr_mode = i_wr && (i_addr == sdamfc_pkg::OFS_MODE);
   assign wr_flt = i_wr && (i_addr == sdamfc_pkg::OFS_FILTER);
   assign wr_cfg = i_wr && (i_addr == sdamfc_pkg::OFS_CONFIG);
   assign mag = magnitude(cur_res);

   // ****************************************************************
   // pin synchronisers and modulator clock choice
   // ****************************************************************
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync1 <= 4'h0;
         sync2 <= 4'h0;
         clk_prev <= 2'h0;
      end else begin
         sync1 <= {i_vt_bit, i_cur_bit, i_lp_osc, i_hf_mod_clk};
         sync2 <= sync1;
         clk_prev <= sync2[1:0];
      end
   end

   // the low-power oscillator replaces the 512 kHz clock, so rates drop by about four
   assign tick = o_lp_clk_sel ? (sync2[1] && !clk_prev[1])
                              : (sync2[0] && !clk_prev[0]);

   // ****************************************************************
   // software registers
   // ****************************************************************
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         converter_mode_register <= sdamfc_pkg::RST_MODE;
      end else if (wr_mode) begin
         converter_mode_register <= i_wdata[7:0];
      end else if (st == sdamfc_pkg::ST_SINGLE && cur_v) begin
         converter_mode_register[sdamfc_pkg::MODE_CONV_LSB +: 3] <= sdamfc_pkg::CONV_OFF;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         decimation_filter_config <= sdamfc_pkg::RST_FILTER;
         converter_config_register <= sdamfc_pkg::RST_CONFIG;
         current_threshold_level <= sdamfc_pkg::RST_THRESH;
         threshold_count_limit <= sdamfc_pkg::RST_TLIMIT;
      end else if (i_wr) begin
         if (i_addr == sdamfc_pkg::OFS_FILTER) begin
            decimation_filter_config <= i_wdata[15:0];
         end
         if (i_addr == sdamfc_pkg::OFS_CONFIG) begin
            converter_config_register <= i_wdata[15:0];
         end
         if (i_addr == sdamfc_pkg::OFS_THRESH) begin
            current_threshold_level <= i_wdata[15:0];
         end
         if (i_addr == sdamfc_pkg::OFS_TLIMIT) begin
            threshold_count_limit <= i_wdata[7:0];
         end
      end
   end

   // effective filter setting; the normal limit still lets chop reach 4 Hz
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         flt_eff <= sdamfc_pkg::RST_FILTER;
      end else begin
         flt_eff <= decimation_filter_config;
         flt_eff.averaging_factor <= clamp_avg(decimation_filter_config.decimation_factor,
            decimation_filter_config.averaging_factor,
            lp ? sdamfc_pkg::PROD_LIM_LP : sdamfc_pkg::PROD_LIM_NORMAL);
      end
   end

   // ****************************************************************
   // conversion sequencing
   // ****************************************************************
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st <= sdamfc_pkg::ST_IDLE;
      end else if (wr_mode) begin
         unique case (i_wdata[sdamfc_pkg::MODE_CONV_LSB +: 3])
            sdamfc_pkg::CONV_CONT: st <= sdamfc_pkg::ST_RUN;
            sdamfc_pkg::CONV_SINGLE: st <= sdamfc_pkg::ST_SINGLE;
            default: st <= sdamfc_pkg::ST_IDLE;
         endcase
      end else begin
         unique case (st)
            sdamfc_pkg::ST_IDLE: st <= sdamfc_pkg::ST_IDLE;
            sdamfc_pkg::ST_RUN: st <= sdamfc_pkg::ST_RUN;
            sdamfc_pkg::ST_SINGLE: begin
               if (cur_v) begin
                  st <= sdamfc_pkg::ST_IDLE;
               end
            end
            default: st <= sdamfc_pkg::ST_IDLE;
         endcase
      end
   end

   // a write to the mode, filter or config register restarts the filters so no mixed-setting result escapes
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         restart <= 1'b0;
         run <= 1'b0;
      end else begin
         restart <= wr_mode || wr_flt || wr_cfg;
         run <= (st != sdamfc_pkg::ST_IDLE) && !restart && !wr_mode && !wr_flt;
      end
   end

   // ****************************************************************
   // analog-side controls
   // ****************************************************************
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_cur_en <= 1'b0;
         o_vt_en <= 1'b0;
         o_lp_clk_sel <= 1'b0;
         o_lp_ref_sel <= 1'b0;
         o_gain_log2 <= 4'h0;
      end else begin
         o_cur_en <= st != sdamfc_pkg::ST_IDLE;
         o_vt_en <= (st != sdamfc_pkg::ST_IDLE) && !lp;
         o_lp_clk_sel <= lp;
         o_lp_ref_sel <= lp && !converter_mode_register[sdamfc_pkg::MODE_REF_BIT];
         if (pwr == sdamfc_pkg::PWR_LP) begin
            o_gain_log2 <= sdamfc_pkg::GAIN_LP_LOG2;
         end else if (pwr == sdamfc_pkg::PWR_LPP) begin
            o_gain_log2 <= sdamfc_pkg::GAIN_LPP_LOG2;
         end else begin
            o_gain_log2 <= converter_config_register[sdamfc_pkg::CFG_GAIN_LSB +: 4];
         end
      end
   end

   // ****************************************************************
   // filters
   // ****************************************************************
   sdamfc_sinc3 u_cur (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_run(run),
      .i_tick(tick),
      .i_bit(sync2[2]),
      .i_cfg(flt_eff),
      .o_valid(cur_v),
      .o_data(cur_res),
      .o_chop(o_cur_chop)
   );

   sdamfc_sinc3 u_vt (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_run(run && !lp),
      .i_tick(tick),
      .i_bit(sync2[3]),
      .i_cfg(flt_eff),
      .o_valid(vt_v),
      .o_data(vt_res),
      .o_chop(o_vt_chop)
   );

   // ****************************************************************
   // results, comparator, counter and accumulator
   // ****************************************************************
   // ready flags: a new result in the read cycle wins over the clear
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cur_data <= '0;
         vt_data <= '0;
         cur_ready <= 1'b0;
         vt_ready <= 1'b0;
         o_cur_valid <= 1'b0;
      end else begin
         o_cur_valid <= cur_v;
         if (cur_v) begin
            cur_data <= cur_res;
            cur_ready <= 1'b1;
         end else if (i_rd && i_addr == sdamfc_pkg::OFS_CUR_DATA) begin
            cur_ready <= 1'b0;
         end
         if (vt_v) begin
            vt_data <= vt_res;
            vt_ready <= 1'b1;
         end else if (i_rd && i_addr == sdamfc_pkg::OFS_VT_DATA) begin
            vt_ready <= 1'b0;
         end
      end
   end

   // the logic runs on the result strobe alone, so all power modes keep it
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_cmp_irq <= 1'b0;
      end else begin
         o_cmp_irq <= cur_v && (cmp_mode != 2'h0) && (mag > current_threshold_level);
      end
   end

   always_comb begin
      next_count = threshold_event_counter;
      if (mag >= current_threshold_level) begin
         next_count = (threshold_event_counter == 8'hFF) ? 8'hFF
                                                         : threshold_event_counter + 8'h01;
      end else if (cmp_mode == 2'h3) begin
         next_count = 8'h00;
      end else if (threshold_event_counter != 8'h00) begin
         next_count = threshold_event_counter - 8'h01;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         threshold_event_counter <= 8'h00;
         o_cnt_irq <= 1'b0;
      end else begin
         o_cnt_irq <= 1'b0;
         if (cmp_mode[1] == 1'b0) begin
            threshold_event_counter <= 8'h00;
         end else if (cur_v) begin
            threshold_event_counter <= next_count;
            o_cnt_irq <= (next_count == threshold_count_limit)
                         && (next_count != threshold_event_counter);
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         current_result_accumulator <= '0;
      end else if (acc_mode == 2'h0 || wr_cfg || wr_flt || wr_mode) begin
         current_result_accumulator <= '0;
      end else if (cur_v) begin
         current_result_accumulator <= (acc_mode == 2'h2)
            ? current_result_accumulator - 32'(cur_res)
            : current_result_accumulator + 32'(cur_res);
      end
   end

   // ****************************************************************
   // read port
   // ****************************************************************
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata <= 32'h0000_0000;
      end else if (i_rd) begin
         unique case (i_addr)
            sdamfc_pkg::OFS_MODE: o_rdata <= {24'h000000, converter_mode_register};
            sdamfc_pkg::OFS_FILTER: o_rdata <= {16'h0000, decimation_filter_config};
            sdamfc_pkg::OFS_CONFIG: o_rdata <= {16'h0000, converter_config_register};
            sdamfc_pkg::OFS_THRESH: o_rdata <= {16'h0000, current_threshold_level};
            sdamfc_pkg::OFS_TCOUNT: o_rdata <= {24'h000000, threshold_event_counter};
            sdamfc_pkg::OFS_TLIMIT: o_rdata <= {24'h000000, threshold_count_limit};
            sdamfc_pkg::OFS_ACCUM: o_rdata <= current_result_accumulator;
            sdamfc_pkg::OFS_CUR_DATA: o_rdata <= {{16{cur_data[15]}}, cur_data};
            sdamfc_pkg::OFS_VT_DATA: o_rdata <= {{16{vt_data[15]}}, vt_data};
            sdamfc_pkg::OFS_STATUS: o_rdata <= {27'h0000000, st, vt_ready, cur_ready};
            default: o_rdata <= 32'h0000_0000;
         endcase
      end else begin
         o_rdata <= 32'h0000_0000;
      end
   end

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   a_filter_reset: assert property ($rose(i_rst_n) |-> decimation_filter_config == 16'h0007)
      else $error("filter config not at reset value");
   a_gain_lp: assert property (pwr == 2'h1 |=> o_gain_log2 == 4'h7)
      else $error("low power gain not forced");
   a_gain_lpp: assert property (pwr == 2'h2 |=> o_gain_log2 == 4'h9)
      else $error("low power plus gain not forced");
   a_lp_vt_off: assert property (lp |=> !o_vt_en && o_lp_clk_sel)
      else $error("voltage channel or clock wrong in low power");
   a_cmp_event: assert property (cur_v && cmp_mode != 2'h0 && mag > current_threshold_level
      |=> o_cmp_irq)
      else $error("comparator event missing");
   a_cnt_clear: assert property (cur_v && cmp_mode == 2'h3 && mag < current_threshold_level
      |=> threshold_event_counter == 8'h00)
      else $error("counter not cleared below threshold");
   a_cnt_inc: assert property (cur_v && cmp_mode[1] && mag >= current_threshold_level
      && threshold_event_counter != 8'hFF
      |=> threshold_event_counter == $past(threshold_event_counter) + 8'h01)
      else $error("counter not incremented");
   a_acc_add: assert property (cur_v && acc_mode == 2'h1 && !i_wr
      |=> current_result_accumulator == $past(current_result_accumulator)
          + 32'($past(cur_res)))
      else $error("accumulator did not add");
   a_acc_clear: assert property (acc_mode == 2'h0 |=> current_result_accumulator == 32'h0)
      else $error("accumulator not cleared");
   a_single_done: assert property (st == sdamfc_pkg::ST_SINGLE && cur_v && !wr_mode
      |=> st == sdamfc_pkg::ST_IDLE ##1 !o_cur_en)
      else $error("single conversion did not power down");
   a_valid_pulse: assert property (o_cur_valid |=> !o_cur_valid)
      else $error("result strobe longer than one cycle");

   c_single: cover property (st == sdamfc_pkg::ST_SINGLE && cur_v);
   c_count_hit: cover property (o_cnt_irq);
   c_lp_result: cover property (lp && o_cur_valid && o_cmp_irq);
endmodule
`default_nettype wire

/* File: src/sdamfc_pkg.sv */
// package: constants, types and register map of the converter mode and filter control
// ****************************************************************
// ****************************************************************
package sdamfc_pkg;
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_FILTER = 8'h04;
   localparam logic [7:0] OFS_CONFIG = 8'h08;
   localparam logic [7:0] OFS_THRESH = 8'h0C;
   localparam logic [7:0] OFS_TCOUNT = 8'h10;
   localparam logic [7:0] OFS_TLIMIT = 8'h14;
   localparam logic [7:0] OFS_ACCUM = 8'h18;
   localparam logic [7:0] OFS_CUR_DATA = 8'h1C;
   localparam logic [7:0] OFS_VT_DATA = 8'h20;
   localparam logic [7:0] OFS_STATUS = 8'h24;
   localparam logic [7:0] RST_MODE = 8'h00;
   localparam logic [15:0] RST_FILTER = 16'h0007;
   localparam logic [15:0] RST_CONFIG = 16'h0000;
   localparam logic [15:0] RST_THRESH = 16'h7FFF;
   localparam logic [7:0] RST_TLIMIT = 8'hFF;
   localparam int MODE_CONV_LSB = 0;
   localparam int MODE_PWR_LSB = 3;
   localparam int MODE_REF_BIT = 5;
   localparam int CFG_CMP_LSB = 3;
   localparam int CFG_ACC_LSB = 5;
   localparam int CFG_GAIN_LSB = 8;
   localparam logic [2:0] CONV_OFF = 3'h0;
   localparam logic [2:0] CONV_CONT = 3'h1;
   localparam logic [2:0] CONV_SINGLE = 3'h2;
   localparam logic [1:0] PWR_NORMAL = 2'h0;
   localparam logic [1:0] PWR_LP = 2'h1;
   localparam logic [1:0] PWR_LPP = 2'h2;
   localparam logic [3:0] GAIN_LP_LOG2 = 4'h7;
   localparam logic [3:0] GAIN_LPP_LOG2 = 4'h9;
   localparam logic [12:0] PROD_LIM_NORMAL = 13'h0780;
   localparam logic [12:0] PROD_LIM_LP = 13'h0800;
   localparam logic [13:0] DECIM_BASE = 14'h0040;
   typedef struct packed {
      logic chop;
      logic ravg;
      logic [5:0] averaging_factor;
      logic modify;
      logic [6:0] decimation_factor;
   } sdamfc_flt_s;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RUN = 3'b010,
      ST_SINGLE = 3'b100
   } sdamfc_state_e;
endpackage

/* File: src/sdamfc_sinc3.sv */
// Sinc3 decimator with chop, averaging and running average for one channel
`timescale 1ns/1ps
`default_nettype none
module sdamfc_sinc3 (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_run,
   input wire logic i_tick,
   input wire logic i_bit,
   input wire sdamfc_pkg::sdamfc_flt_s i_cfg,
   output logic o_valid,
   output logic signed [15:0] o_data,
   output logic o_chop
);
   logic signed [39:0] i1, i2, i3, i3_cap, z1, z2;
   logic [13:0] phase;
   logic [1:0] fill;
   logic [5:0] avg_cnt;
   logic signed [21:0] avg_sum;
   logic signed [15:0] prev;
   logic [13:0] n_dec;
   logic [13:0] cap_ph;
   logic signed [39:0] x, n1, n2, n3, z, y, ys;
   logic signed [15:0] s, a;
   logic signed [21:0] sum_n;
   logic [5:0] sh;
   // window is 64*(factor+1) ticks, so a zero factor runs at 8 kHz
   // modify shortens the third stage to 3/4 of the window
   always_comb begin
      n_dec = 14'((i_cfg.decimation_factor + 14'h0001) * sdamfc_pkg::DECIM_BASE);
      cap_ph = i_cfg.modify ? {2'b00, n_dec[13:2]} : 14'h0000;
      x = i_bit ? 40'sh1 : -40'sh1;
      n1 = i1 + x;
      n2 = i2 + n1;
      n3 = i3 + n2;
      z = n3 - i3_cap;
      y = z - (z1 <<< 1) + z2;
      sh = 6'(3 * (6 + $clog2(i_cfg.decimation_factor + 8'h01)));
      ys = y >>> (sh - 6'd15);
      s = (i_cfg.chop && o_chop) ? -ys[15:0] : ys[15:0];
      sum_n = avg_sum + 22'(s);
      a = 16'(sum_n / $signed({2'b00, i_cfg.averaging_factor} + 8'h01));
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         {i1, i2, i3, i3_cap, z1, z2} <= '0;
         phase <= 14'h0000;
         fill <= 2'h0;
         avg_cnt <= 6'h00;
         avg_sum <= '0;
         prev <= '0;
         o_valid <= 1'b0;
         o_data <= '0;
         o_chop <= 1'b0;
      end else if (!i_run) begin
         {i1, i2, i3, i3_cap, z1, z2} <= '0;
         phase <= 14'h0000;
         fill <= 2'h0;
         avg_cnt <= 6'h00;
         avg_sum <= '0;
         o_valid <= 1'b0;
         o_chop <= 1'b0;
      end else begin
         o_valid <= 1'b0;
         if (i_tick) begin
            i1 <= n1;
            i2 <= n2;
            i3 <= n3;
            if (phase == cap_ph) begin
               i3_cap <= n3;
            end
            phase <= (phase == n_dec - 14'h0001) ? 14'h0000 : phase + 14'h0001;
            if (phase == n_dec - 14'h0001) begin
               z1 <= z;
               z2 <= z1;
               // the comb pipeline needs three windows before its output is true
               if (fill != 2'h3) begin
                  fill <= fill + 2'h1;
               end else begin
                  o_chop <= ~o_chop;
                  if (avg_cnt == i_cfg.averaging_factor) begin
                     avg_cnt <= 6'h00;
                     avg_sum <= '0;
                     o_valid <= 1'b1;
                     prev <= a;
                     o_data <= i_cfg.ravg ? 16'((17'(a) + 17'(prev)) >>> 1) : a;
                  end else begin
                     avg_cnt <= avg_cnt + 6'h01;
                     avg_sum <= sum_n;
                  end
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

/* File: testbench/sdamfc_mod_model.sv */
// modulator stand-in: clock sources and bit streams of the analog front end
`timescale 1ns/1ps
`default_nettype none
module sdamfc_mod_model (
   input wire logic i_pos,
   output var logic o_hf_clk,
   output var logic o_lp_clk,
   output var logic o_cur_bit,
   output var logic o_vt_bit
);
   initial {o_hf_clk, o_lp_clk, o_cur_bit, o_vt_bit} = 4'h0;
   // the 512 kHz source never stops, as software keeps the PLL up in normal mode
   always #976.5 o_hf_clk = ~o_hf_clk;
   always #3817 o_lp_clk = ~o_lp_clk;
   // a zero input modulates as alternating ones and zeros
   always @(negedge o_hf_clk or negedge o_lp_clk) begin
      o_cur_bit <= i_pos | ~o_cur_bit;
      o_vt_bit <= ~o_vt_bit;
   end
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// self-checking bench for the converter mode and filter control
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic i_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, rp = 1'b0;
   logic [7:0] i_addr = 8'h00;
   logic [31:0] i_wdata = 32'h0, o_rdata;
   logic [3:0] o_gain_log2;
   logic o_cur_en, o_vt_en, o_lp_clk_sel, o_lp_ref_sel, o_cur_chop, o_vt_chop;
   logic o_cur_valid, o_cmp_irq, o_cnt_irq, hf, lp, cb, vb;
   logic [31:0] rq[$];
   logic [1:0] cq[$];
   logic [7:0] modes[4] = '{8'h09, 8'h11, 8'h29, 8'h01};
   logic [7:0] outs[4] = '{8'hB7, 8'hB9, 8'hA7, 8'hC0};
   int err_count = 0, cmp_count = 0;
   always #12.5 i_clk = ~i_clk;
   sdamfc_mod_model sdamfc_mod_model_inst (.i_pos(1'b1), .o_hf_clk(hf), .o_lp_clk(lp),
      .o_cur_bit(cb), .o_vt_bit(vb));
   sdamfc_top sdamfc_top_inst (.i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
      .i_hf_mod_clk(hf), .i_lp_osc(lp), .i_cur_bit(cb), .i_vt_bit(vb), .o_cur_en, .o_vt_en,
      .o_lp_clk_sel, .o_lp_ref_sel, .o_gain_log2, .o_cur_chop, .o_vt_chop, .o_cur_valid,
      .o_cmp_irq, .o_cnt_irq);
   // ****************************************
   // shared tasks and the result monitor
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // a read notes its expected word; the monitor checks it in the following cycle
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= w;
      i_rd <= ~w;
      if (!w) rq.push_back(d);
      @(posedge i_clk);
      i_wr <= 1'b0;
      i_rd <= 1'b0;
   endtask
   task automatic drain;
      for (int i = 0; i < 40000 && cq.size() > 0; i++) @(posedge i_clk);
      chk(32'(cq.size()), 32'h0);
   endtask
   always @(negedge i_clk) begin
      if (rp && rq.size() > 0) chk(o_rdata, rq.pop_front());
      if (o_cur_valid && cq.size() > 0)
         chk({30'h0, o_cnt_irq, o_cmp_irq}, {30'h0, cq.pop_front()});
      if (o_cur_valid) chk({31'h0, o_vt_chop}, {31'h0, o_cur_chop});
      rp = i_rd;
   end
   task automatic final_report;
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #2400us;
      err_count++;
      final_report();
   end
   initial begin
      void'($urandom(88));
      repeat (2) @(posedge i_clk);
      i_rst_n <= 1'b1;
      bus(0, sdamfc_pkg::OFS_FILTER, 32'h0000_0007);
      bus(0, sdamfc_pkg::OFS_MODE, 32'h0);
      bus(0, sdamfc_pkg::OFS_THRESH, 32'h0000_7FFF);
      bus(0, sdamfc_pkg::OFS_TLIMIT, 32'h0000_00FF);
      bus(0, 8'h3C, 32'h0);
      $display("test reset values done");
      bus(1, sdamfc_pkg::OFS_THRESH, {24'h0, 8'($urandom)});
      bus(1, sdamfc_pkg::OFS_CONFIG, 32'h0000_0030);
      bus(1, sdamfc_pkg::OFS_TLIMIT, 32'h0000_0002);
      bus(1, sdamfc_pkg::OFS_FILTER, 32'h0);
      foreach (modes[i]) begin
         bus(1, sdamfc_pkg::OFS_MODE, {24'h0, modes[i]});
         repeat (4) @(posedge i_clk);
         chk({24'h0, o_cur_en, o_vt_en, o_lp_clk_sel, o_lp_ref_sel, o_gain_log2},
            {24'h0, outs[i]});
      end
      $display("test power modes done");
      cq.push_back(2'b01);
      cq.push_back(2'b11);
      drain();
      bus(0, sdamfc_pkg::OFS_TCOUNT, 32'h0000_0002);
      bus(1, sdamfc_pkg::OFS_THRESH, 32'h0000_7FFF);
      repeat (2) @(posedge i_clk);
      repeat (2) cq.push_back(2'b00);
      drain();
      bus(0, sdamfc_pkg::OFS_TCOUNT, 32'h0);
      $display("test comparator done");
      bus(1, sdamfc_pkg::OFS_CONFIG, 32'h0000_0008);
      bus(0, sdamfc_pkg::OFS_ACCUM, 32'h0);
      bus(1, sdamfc_pkg::OFS_MODE, 32'h0000_0002);
      cq.push_back(2'b00);
      for (int i = 0; i < 40000 && (o_cur_en !== 1'b0 || cq.size() > 0); i++) @(posedge i_clk);
      chk({31'h0, o_cur_en}, 32'h0);
      bus(0, sdamfc_pkg::OFS_MODE, 32'h0);
      repeat (2) @(posedge i_clk);
      $display("test single conversion done");
      final_report();
   end
endmodule
`default_nettype wire
